// ---- bench/i2c_master_model.sv ----
// two-wire bus master that writes one selection byte per transfer
module i2c_master_model
(
  input  wire logic mclk,
  input  wire logic sda_w,
  output logic      scl_m,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 1ps;
  initial scl_m = 1'b1;
  initial sda_m = 1'b1;
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // 160 ns bus period: low five cycles, high three; the long low phase lets the
  // slave's late acknowledge release settle before the next rise
  task automatic bit_io(input logic b, output logic r);
    tk(1);
    sda_m <= b;
    tk(4);
    scl_m <= 1'b1;
    tk(2);
    r = sda_w;
    tk(1);
    scl_m <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] f, input logic [7:0] d, output logic aa, output logic ad);
    logic r;
    sda_m <= 1'b0;
    tk(8);
    scl_m <= 1'b0;
    for (int i = 7; i >= 0; i--)
      bit_io(f[i], r);
    bit_io(1'b1, r);
    aa = ~r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ad = ~r;
    tk(1);
    sda_m <= 1'b0;
    tk(4);
    scl_m <= 1'b1;
    tk(8);
    sda_m <= 1'b1;
    tk(8);
  endtask
endmodule

// ---- bench/sd_clock_mux_tb_top.sv ----
// self-checking testbench for the card clock multiplexer
module sd_clock_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk;
  logic        rstn = 1'b0;
  logic        host = 1'b0;
  logic [31:0] rng = 32'ha553;
  logic        scl_m, sda_m, aa, ad, nxt;
  logic        cur = sdmux_pkg::SEL_RST;
  logic        exp_q[$];
  int          fail_count = 0;
  int          n_checks = 0;
  wire logic   scl_o, scl_oe_n, sda_o, sda_oe_n, ca, cb, sel;
  wire logic   scl_w = scl_m & (scl_oe_n | scl_o);
  wire logic   sda_w = sda_m & (sda_oe_n | sda_o);
  localparam logic [7:0] FA [6] = '{8'h00, 8'h00, 8'h2a, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] DA [6] = '{8'hff, 8'h00, 8'hff, 8'hff, 8'h5a, 8'hff};
  localparam logic       OK [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  sd_clock_mux i_sd_clock_mux
  (
    .mclk(mclk), .rstn(rstn), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .host_card_clock_in(host),
    .card_a_clock_out(ca), .card_b_clock_out(cb), .sel_status(sel)
  );
  i2c_master_model i_i2c_master_model
  (
    .mclk(mclk), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m)
  );
  task automatic check(input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    rng <= xs(rng);
    host <= rng[0];
  end
  initial
  begin
    wait (rstn === 1'b1);
    forever
    begin
      @(sel);
      if (exp_q.size() == 0)
        check(1'b0, 1'b1);
      else
        check(sel, exp_q.pop_front());
    end
  end
  initial
  begin
    #100us;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    check(sel, sdmux_pkg::SEL_RST);
    for (int i = 0; i < 6; i++)
    begin
      nxt = cur;
      if (OK[i] && DA[i] == sdmux_pkg::SEL_CODE_A)
        nxt = 1'b0;
      if (OK[i] && DA[i] == sdmux_pkg::SEL_CODE_B)
        nxt = 1'b1;
      if (nxt !== cur)
        exp_q.push_back(nxt);
      cur = nxt;
      i_i2c_master_model.xfer(FA[i], DA[i], aa, ad);
      check(aa, OK[i]);
      check(ad, OK[i]);
      check(sel, cur);
      check(ca, host & !cur);
      check(cb, host & cur);
    end
    exp_q.push_back(sdmux_pkg::SEL_RST);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    check(exp_q.size() == 0, 1'b1);
    tally_and_finish();
  end
endmodule

// ---- bench/sdmux_monitor.sv ----
// port checker for the card clock multiplexer
module sdmux_monitor
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic host_card_clock_in,
  input wire logic card_a_clock_out,
  input wire logic card_b_clock_out,
  input wire logic sel_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_ca; card_a_clock_out == (host_card_clock_in & ~sel_status); endproperty
  a_ca: assert property (p_ca) else $error("card a clock");
  property p_cb; card_b_clock_out == (host_card_clock_in & sel_status); endproperty
  a_cb: assert property (p_cb) else $error("card b clock");
  property p_od; !scl_o && !sda_o && scl_oe_n; endproperty
  a_od: assert property (p_od) else $error("pin driven");
  property p_sel; $changed(sel_status) |-> $fell(sda_oe_n); endproperty
  a_sel: assert property (p_sel) else $error("stray select");
  property p_ack; $fell(sda_oe_n) |-> !sda_oe_n [*8] ##[1:16] sda_oe_n; endproperty
  a_ack: assert property (p_ack) else $error("ack length");
  property p_al; $fell(sda_oe_n) |-> !scl_i; endproperty
  a_al: assert property (p_al) else $error("ack on high");
  property p_rl; $rose(sda_oe_n) |-> !scl_i; endproperty
  a_rl: assert property (p_rl) else $error("release on high");
  property p_rst; $rose(rstn) |-> !sel_status && sda_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_b: cover property ($rose(sel_status));
  c_a: cover property ($fell(sel_status));
  c_ack: cover property ($fell(sda_oe_n));
endmodule
bind sd_clock_mux sdmux_monitor i_sdmux_monitor (.*);

// ---- logic/line_event_if.sv ----
// carries synchronised bus lines and their decoded events between modules
interface line_event_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  modport src
  (
    output scl,
    output sda,
    output scl_rise,
    output scl_fall,
    output start_ev,
    output stop_ev
  );
  modport dst
  (
    input scl,
    input sda,
    input scl_rise,
    input scl_fall,
    input start_ev,
    input stop_ev
  );
endinterface

// ---- logic/line_sync.sv ----
// three-stage pin synchroniser and edge / start / stop detection for the two-wire bus
module line_sync
(
  input  wire logic   mclk,
  input  wire logic   rstn,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  line_event_if.src   ev
);
  // lines idle high, so reset to released level
  logic [sdmux_pkg::SYNC_STAGES-1:0] scl_q;
  logic [sdmux_pkg::SYNC_STAGES-1:0] sda_q;
  logic                              scl_st_q;
  logic                              sda_st_q;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_q <= '1;
      sda_q <= '1;
    end
    else
    begin
      scl_q <= {scl_q[sdmux_pkg::SYNC_STAGES-2:0], scl_i};
      sda_q <= {sda_q[sdmux_pkg::SYNC_STAGES-2:0], sda_i};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_st_q <= 1'b1;
      sda_st_q <= 1'b1;
    end
    else
    begin
      if (scl_q[1] == scl_q[2])
        scl_st_q <= scl_q[2];
      if (sda_q[1] == sda_q[2])
        sda_st_q <= sda_q[2];
    end
  end

  logic scl_new;
  logic sda_new;
  assign scl_new     = (scl_q[1] == scl_q[2]) ? scl_q[2] : scl_st_q;
  assign sda_new     = (sda_q[1] == sda_q[2]) ? sda_q[2] : sda_st_q;
  assign ev.scl      = scl_st_q;
  assign ev.sda      = sda_st_q;
  assign ev.scl_rise = !scl_st_q && scl_new;
  assign ev.scl_fall = scl_st_q && !scl_new;
  // data moving while the clock stays high marks start or stop
  assign ev.start_ev = scl_st_q && scl_new && sda_st_q && !sda_new;
  assign ev.stop_ev  = scl_st_q && scl_new && !sda_st_q && sda_new;
endmodule

// ---- logic/sd_clock_mux.sv ----
// two-wire slave that steers the host card clock to card a or card b
// Summary of operation
// (RQ1) host card clock goes to exactly one card output, chosen by last byte
// (RQ2) only the card clock is switched; data lines bypass this block
// (RQ3) acts as two-wire slave with a seven bit address
// (RQ4) master opens with start, seven address bits, then direction bit
// (RQ5) matching address is acknowledged right after the direction bit
// (RQ6) master then sends one selection byte
// (RQ7) selection byte is acknowledged with a second acknowledge
// (RQ8) master ends each transaction with stop
// (RQ9) byte 00 selects card a, byte ff selects card b; status follows
// (RQ10) a dedicated status output shows the current selection continuously
// (RQ11) bus pins only pulled low or released, never driven high
// (RQ12) demonstrated address is 00h
// (RQ13) address mismatch: no acknowledge, rest ignored, selection kept
// (RQ14) selection holds between transactions; resets to card a
module sd_clock_mux
#(
  parameter logic [6:0] SLAVE_ADDR = sdmux_pkg::SLAVE_ADDR_RST
)
(
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic scl_i,
  output wire logic scl_o,
  output wire logic scl_oe_n,
  input  wire logic sda_i,
  output wire logic sda_o,
  output wire logic sda_oe_n,
  input  wire logic host_card_clock_in,
  output wire logic card_a_clock_out,
  output wire logic card_b_clock_out,
  output wire logic sel_status
);
  line_event_if ev ();

  line_sync u_sync
  (
    .mclk  (mclk),
    .rstn  (rstn),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ev    (ev)
  );

  sdmux_pkg::slave_state_t state_q;
  logic [3:0]              bit_cnt_q;
  logic [7:0]              shift_q;
  logic                    sel_q;
  logic                    sda_low_q;

  // every byte takes eight rising clocks before its ninth, acknowledge slot
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q   <= sdmux_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
    end
    else if (ev.start_ev)
    begin
      // repeated start restarts the address phase
      state_q   <= sdmux_pkg::ST_ADDR; // RQ4
      bit_cnt_q <= 4'h0;
    end
    else if (ev.stop_ev)
    begin
      state_q <= sdmux_pkg::ST_IDLE; // RQ8
    end
    else
    begin
      case (state_q)
        sdmux_pkg::ST_ADDR,
        sdmux_pkg::ST_DATA:
        begin
          if (ev.scl_rise)
          begin
            shift_q   <= {shift_q[6:0], ev.sda}; // RQ3
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (ev.scl_fall && bit_cnt_q == sdmux_pkg::ACK_BIT_CNT)
          begin
            bit_cnt_q <= 4'h0;
            if (state_q == sdmux_pkg::ST_DATA)
              state_q <= sdmux_pkg::ST_ACK_DATA; // RQ7
            // only a write to our address is taken; reads are not served
            else if (shift_q[7:sdmux_pkg::ADDR_POS] == SLAVE_ADDR
                     && !shift_q[sdmux_pkg::RW_POS])
              state_q <= sdmux_pkg::ST_ACK_ADDR; // RQ5
            else
              state_q <= sdmux_pkg::ST_IGNORE; // RQ13
          end
        end
        sdmux_pkg::ST_ACK_ADDR:
        begin
          if (ev.scl_fall)
            state_q <= sdmux_pkg::ST_DATA; // RQ6
        end
        sdmux_pkg::ST_ACK_DATA:
        begin
          // further bytes are also acknowledged, the last one wins
          if (ev.scl_fall)
            state_q <= sdmux_pkg::ST_DATA;
        end
        sdmux_pkg::ST_IGNORE:
        begin
          state_q <= sdmux_pkg::ST_IGNORE; // RQ13
        end
        default:
        begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // selection updates only on a fully received byte of a matching write
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sel_q <= sdmux_pkg::SEL_RST; // RQ14
    else if (state_q == sdmux_pkg::ST_DATA && !ev.start_ev && !ev.stop_ev && ev.scl_fall
             && bit_cnt_q == sdmux_pkg::ACK_BIT_CNT)
    begin
      if (shift_q == sdmux_pkg::SEL_CODE_A)
        sel_q <= 1'b0; // RQ9
      else if (shift_q == sdmux_pkg::SEL_CODE_B)
        sel_q <= 1'b1; // RQ9
    end
  end

  // acknowledge held low across the whole ninth clock
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sda_low_q <= 1'b0;
    else if (ev.start_ev || ev.stop_ev)
      sda_low_q <= 1'b0;
    else if (ev.scl_fall)
      sda_low_q <= bit_cnt_q == sdmux_pkg::ACK_BIT_CNT
                   && (state_q == sdmux_pkg::ST_DATA
                       || (state_q == sdmux_pkg::ST_ADDR
                           && shift_q[7:sdmux_pkg::ADDR_POS] == SLAVE_ADDR
                           && !shift_q[sdmux_pkg::RW_POS])); // RQ5 RQ7 RQ13
  end

  assign sda_o    = 1'b0; // RQ11
  assign sda_oe_n = !sda_low_q; // RQ11
  // no clock stretching: the serial clock is never pulled
  assign scl_o    = 1'b0; // RQ11
  assign scl_oe_n = 1'b1; // RQ11

  // combinational gating keeps the card clock free of sampling jitter;
  // a selection change may clip one card clock pulse
  assign card_a_clock_out = host_card_clock_in & !sel_q; // RQ1 RQ2
  assign card_b_clock_out = host_card_clock_in & sel_q; // RQ1 RQ2
  assign sel_status       = sel_q; // RQ10
endmodule

// ---- logic/sdmux_pkg.sv ----
// shared constants and types for the two-wire controlled card clock multiplexer
package sdmux_pkg;
  localparam logic [6:0] SLAVE_ADDR_RST = 7'h00;
  localparam logic [7:0] SEL_CODE_A     = 8'h00;
  localparam logic [7:0] SEL_CODE_B     = 8'hff;
  localparam logic       SEL_RST        = 1'b0;
  localparam int         SYNC_STAGES    = 3;
  localparam int         ADDR_POS       = 1;
  localparam int         RW_POS         = 0;
  localparam logic [3:0] ACK_BIT_CNT    = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_DATA,
    ST_ACK_DATA,
    ST_IGNORE
  } slave_state_t;
endpackage
